// file: sim/pft_evt_src.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Event pin source: toggles the pin on command
// ------------------------------------------------------------
module pft_evt_src (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic fire_i,
   input wire logic slow_i,
   output logic pin_o
);
   logic lvl_ff; // Pin level, idles high as with a pull-up
   logic [3:0] dly_ff; // Cycles left before the toggle
   assign pin_o = lvl_ff;
   // Toggle after a short or a long delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_ff <= 1'b1;
         dly_ff <= 4'h0;
      end else if (fire_i) begin
         dly_ff <= slow_i ? 4'h8 : 4'h1;
      end else if (dly_ff != 4'h0) begin
         dly_ff <= dly_ff - 4'h1;
         if (dly_ff == 4'h1) begin
            lvl_ff <= ~lvl_ff;
         end
      end
   end
endmodule

// file: sim/tb_pft_top.sv
`timescale 1ns/1ps
module tb_pft_top
   import pft_pkg::*;
;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, stop = 0, fire = 0, slow = 0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, rd;
   logic ack, pin, fa_flag, mt_flag;
   logic [7:0] v;
   int n_errors = 0, total_checks = 0, cyc_cnt = 0, p;
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) cyc_cnt <= cyc_cnt + 1;
   pft_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .stop_mode_i(stop), .event_trigger_pin_i(pin), .free_timer_overflow_flag_o(fa_flag),
      .multi_timer_request_flag_o(mt_flag));
   pft_evt_src evt (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .slow_i(slow), .pin_o(pin));
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   // Classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [5:0] idx, input logic [3:0] d, output logic [31:0] r);
      int n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'hF;
      wdat <= {28'h0, d};
      // Wait for the answer however long it takes; only the watchdog ends a hang
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1);
      // Taken at the first edge, ack seen high at the second
      chk("ack delay", n[15:0], 16'h0002);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [3:0] d);
      wb(1'b1, idx, d, rd);
   endtask
   task automatic rdc(input string nm, input logic [5:0] idx, input logic [3:0] e);
      wb(1'b0, idx, 4'h0, rd);
      chk(nm, rd[15:0], {12'h0, e});
   endtask
   // Mode one write, then let it settle before loading
   task automatic mode1(input logic [3:0] m);
      wr(IDX_TB_MODE1, m);
      repeat (3) @(posedge clk_i);
   endtask
   task automatic load(input logic [7:0] x);
      wr(IDX_TB_LOW, x[3:0]);
      wr(IDX_TB_HIGH, x[7:4]);
   endtask
   // High digit first, as software must
   task automatic rd_cnt(output logic [7:0] x);
      logic [31:0] h;
      wb(1'b0, IDX_TB_HIGH, 4'h0, h);
      wb(1'b0, IDX_TB_LOW, 4'h0, rd);
      x = {h[3:0], rd[3:0]};
   endtask
   // Pin toggles, prompt and slow in turn, well spaced
   task automatic toggles(input int k);
      repeat (k) begin
         @(posedge clk_i);
         fire <= 1'b1;
         slow <= ~slow;
         @(posedge clk_i);
         fire <= 1'b0;
         repeat (16) @(posedge clk_i);
      end
   endtask
   task automatic wait_fa(output int t);
      int n = 0;
      while (fa_flag !== 1'b1 && n < 5000) begin
         @(posedge clk_i);
         n++;
      end
      chk("free flag wait", {15'h0, fa_flag}, 16'h1);
      t = cyc_cnt;
   endtask
   task automatic free_period(output int q);
      int t0, t1;
      wait_fa(t0);
      wr(IDX_FREE_FLAG, 4'h0);
      wait_fa(t1);
      q = t1 - t0;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rdc("free flag", IDX_FREE_FLAG, 4'h0);
      rdc("req flag", IDX_MULTI_FLAG, 4'h0);
      rdc("cap flags", IDX_CAP_FLAGS, 4'h0);
      rdc("mode a wo", IDX_TA_MODE, 4'h0);
      rdc("unmapped", 6'h3F, 4'h0);
      chk("req out", {15'h0, mt_flag}, 16'h0);
      $display("test reset done");
   endtask
   task automatic t_free;
      free_period(p);
      chk("period tap0", p[15:0], 16'h0200);
      wr(IDX_TA_MODE, 4'h1);
      free_period(p);
      free_period(p);
      chk("period tap1", p[15:0], 16'h0400);
      stop <= 1'b1;
      wr(IDX_FREE_FLAG, 4'h0);
      repeat (2100) @(posedge clk_i);
      chk("stop holds", {15'h0, fa_flag}, 16'h0);
      stop <= 1'b0;
      $display("test free timer done");
   endtask
   task automatic t_load;
      logic [31:0] h;
      mode1(4'h7);
      wr(IDX_TB_HIGH, 4'h3);
      rd_cnt(v);
      chk("low reset", {8'h0, v}, 16'h30);
      load(8'hA5);
      rd_cnt(v);
      chk("load", {8'h0, v}, 16'hA5);
      wr(IDX_TB_LOW, 4'h3);
      rd_cnt(v);
      chk("low only", {8'h0, v}, 16'hA5);
      wr(IDX_TB_HIGH, 4'hC);
      rd_cnt(v);
      chk("high only", {8'h0, v}, 16'hC3);
      mode1(4'h0);
      load(8'h00);
      wb(1'b0, IDX_TB_HIGH, 4'h0, h);
      repeat (40) @(posedge clk_i);
      wb(1'b0, IDX_TB_LOW, 4'h0, rd);
      chk("high read", h[15:0], 16'h0);
      // Exactly one tap-0 tick falls between the load edge and the latching read
      chk("low latched", {12'h0, rd[3:0]}, 16'h0001);
      $display("test load done");
   endtask
   task automatic t_event;
      wr(IDX_PIN_SEL, 4'h4);
      mode1(4'h7);
      for (int c = 0; c < 4; c++) begin
         wr(IDX_TB_MODE2, c[3:0]);
         load(8'h10);
         toggles(4);
         rd_cnt(v);
         chk("edges", {8'h0, v}, (c == 0) ? 16'h10 : (c == 3) ? 16'h14 : 16'h12);
      end
      $display("test event done");
   endtask
   task automatic t_ovf;
      wr(IDX_TB_MODE2, 4'h3);
      mode1(4'hF);
      load(8'hFE);
      // Clear the flag left over from earlier free counting
      wr(IDX_MULTI_FLAG, 4'h0);
      toggles(2);
      rd_cnt(v);
      chk("reload", {8'h0, v}, 16'hFE);
      chk("req set", {15'h0, mt_flag}, 16'h1);
      wr(IDX_MULTI_FLAG, 4'h0);
      repeat (2) @(posedge clk_i);
      chk("req clear", {15'h0, mt_flag}, 16'h0);
      mode1(4'h7);
      load(8'hFF);
      toggles(1);
      rd_cnt(v);
      chk("wrap", {8'h0, v}, 16'h00);
      chk("req wrap", {15'h0, mt_flag}, 16'h1);
      $display("test overflow done");
   endtask
   task automatic t_cap;
      logic [31:0] l, h;
      wr(IDX_MULTI_FLAG, 4'h0);
      mode1(4'h0);
      wr(IDX_TB_MODE2, 4'h7);
      toggles(1);
      rdc("status", IDX_CAP_FLAGS, 4'h1);
      chk("req cap", {15'h0, mt_flag}, 16'h1);
      wb(1'b0, IDX_TB_LOW, 4'h0, l);
      wb(1'b0, IDX_TB_HIGH, 4'h0, h);
      repeat (30) @(posedge clk_i);
      rd_cnt(v);
      chk("any order", {8'h0, h[3:0], l[3:0]}, {8'h0, v});
      toggles(1);
      rdc("err edge", IDX_CAP_FLAGS, 4'h3);
      wr(IDX_CAP_FLAGS, 4'h0);
      rdc("cleared", IDX_CAP_FLAGS, 4'h0);
      toggles(1);
      rdc("status2", IDX_CAP_FLAGS, 4'h1);
      repeat (600) @(posedge clk_i);
      rdc("err ovf", IDX_CAP_FLAGS, 4'h3);
      $display("test capture done");
   endtask
   // ------------------------------------------------------------
   // Verdict, main sequence, watchdog
   // ------------------------------------------------------------
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_free();
      t_load();
      t_event();
      t_ovf();
      t_cap();
      tally_and_finish();
   end
   initial begin
      repeat (30000) @(posedge clk_i);
      n_errors++;
      tally_and_finish();
   end
endmodule

// file: verilog/pft_pkg.sv
package pft_pkg;
   // ------------------------------------------------------------
   // Widths and counter values
   // ------------------------------------------------------------
   localparam int PSC_W = 11;
   localparam logic [10:0] PSC_RST = 11'h000;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [3:0] NIB_RST = 4'h0;
   localparam logic [2:0] MODE2_RST = 3'h0;
   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [5:0] IDX_FREE_FLAG = 6'h01;
   localparam logic [5:0] IDX_MULTI_FLAG = 6'h02;
   localparam logic [5:0] IDX_TA_MODE = 6'h08;
   localparam logic [5:0] IDX_TB_MODE1 = 6'h09;
   localparam logic [5:0] IDX_TB_LOW = 6'h0A;
   localparam logic [5:0] IDX_TB_HIGH = 6'h0B;
   localparam logic [5:0] IDX_CAP_FLAGS = 6'h21;
   localparam logic [5:0] IDX_PIN_SEL = 6'h24;
   localparam logic [5:0] IDX_TB_MODE2 = 6'h26;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int FREE_FLAG_BIT = 2;
   localparam int MULTI_FLAG_BIT = 0;
   localparam int CSF_BIT = 0;
   localparam int CEF_BIT = 1;
   localparam int PIN_EVT_BIT = 2;
   localparam int RELOAD_BIT = 3;
   localparam int CAP_EN_BIT = 2;
   localparam logic [2:0] SRC_EXT = 3'h7;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_LAT_CYC = 2'h2;
   // Tap masks: tap k ticks when the masked prescaler bits are all one
   localparam logic [10:0] TAP_MASK [0:7] = '{11'h001, 11'h003, 11'h007, 11'h00F,
                                             11'h03F, 11'h0FF, 11'h3FF, 11'h7FF};
   // Event edge selection
   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_FALL = 2'b01,
      EDGE_RISE = 2'b10,
      EDGE_BOTH = 2'b11
   } pft_edge_t;
endpackage

// file: verilog/pft_top.sv
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
// Function
// - 11-bit prescaler, reset zero, divides continuously
// - Prescaler halts in stop mode
// - Free timer resets zero, counts selected ticks
// - Free timer wraps at FF, sets flag
// - Free timer source from 4-bit mode register
// - Multi timer loaded by software, then counts
// - Overflow reloads or restarts from zero
// - Overflow sets request flag, software clears
// - Event mode counts selected pin edges
// - Capture copies count, flags, clears timer
// - Trigger or overflow while captured: error
// - Status and error cleared by writing zero
// - Mode one takes effect two cycles later
// - Mode two: edge select, capture enable
// - High load write loads both digits
// - Low load digit resets to zero
// - High read latches low digit outside capture mode
// - Captured digits readable in any order
module pft_top
   import pft_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic stop_mode_i,
   input wire logic event_trigger_pin_i,
   output logic free_timer_overflow_flag_o,
   output logic multi_timer_request_flag_o
);

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Tick of a prescaler tap
   function automatic logic tap_tick(input logic [10:0] p, input logic [2:0] sel);
      logic [10:0] m;
      m = TAP_MASK[sel];
      return (p & m) == m;
   endfunction

   // Edge selection decode
   function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
      logic hit;
      hit = 1'b0;
      case (pft_edge_t'(sel))
         EDGE_FALL: hit = fall;
         EDGE_RISE: hit = rise;
         EDGE_BOTH: hit = rise | fall;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [10:0] psc_ff; // System prescaler
   logic [7:0] ta_ff; // Free-running timer count
   logic [7:0] tb_ff; // Multifunction timer count
   logic [3:0] tma_ff; // Free timer mode
   logic [3:0] timer_b_mode_one_pend_ff; // Written mode one, pending
   logic [3:0] timer_b_mode_one_ff; // Active mode one
   logic [1:0] lag_ff; // Mode one settle counter
   logic [2:0] timer_b_mode_two_ff; // Mode two
   logic [3:0] timer_b_load_low_ff; // Load low digit
   logic [3:0] timer_b_load_high_ff; // Load high digit
   logic [3:0] event_pin_function_select_ff; // Pin function select
   logic [7:0] cap_ff; // Captured count
   logic [3:0] lat_ff; // Latched low digit
   logic free_timer_overflow_flag_ff; // Free timer overflow flag
   logic multi_timer_request_flag_ff; // Multi timer request flag
   logic capture_status_flag_ff; // Capture status flag
   logic capture_error_flag_ff; // Capture error flag
   logic s1_ff, s2_ff, s3_ff; // Pin synchroniser
   logic lvl_ff; // Filtered pin level
   logic lvl_ok_ff; // Filtered level is valid
   logic ack_ff; // Bus acknowledge
   logic [31:0] rd_ff; // Bus read data

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic take; // Request taken this edge
   logic wr; // Write taken
   logic rd; // Read taken
   logic [5:0] idx; // Register index
   logic [3:0] wd; // Written nibble
   assign take = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign idx = wb_adr_i[7:2];
   assign wr = take & wb_we_i & wb_sel_i[0];
   assign rd = take & ~wb_we_i;
   assign wd = wb_dat_i[3:0];

   logic wr_tb_low, wr_tb_high, wr_ifa, wr_ifb, wr_cap;
   assign wr_tb_low = wr & (idx == IDX_TB_LOW);
   assign wr_tb_high = wr & (idx == IDX_TB_HIGH);
   assign wr_ifa = wr & (idx == IDX_FREE_FLAG);
   assign wr_ifb = wr & (idx == IDX_MULTI_FLAG);
   assign wr_cap = wr & (idx == IDX_CAP_FLAGS);

   // ------------------------------------------------------------
   // Event pin synchroniser and edge filter
   // ------------------------------------------------------------
   // Three stages, no reset: they already hold the pin level when reset ends
   always_ff @(posedge clk_i) begin
      s1_ff <= event_trigger_pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
   end

   logic agree, rise, fall, evt_edge, pin_en;
   assign agree = (s2_ff == s3_ff); // A change counts once stages two and three agree
   // First valid level after reset gives no edge
   assign rise = agree & lvl_ok_ff & s3_ff & ~lvl_ff;
   assign fall = agree & lvl_ok_ff & ~s3_ff & lvl_ff;
   // Pin only acts when set to its event function
   assign pin_en = event_pin_function_select_ff[PIN_EVT_BIT];
   assign evt_edge = pin_en & edge_hit(timer_b_mode_two_ff[1:0], rise, fall);

   // Filtered level
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lvl_ff <= 1'b0;
         lvl_ok_ff <= 1'b0;
      end else if (agree) begin
         lvl_ff <= s3_ff;
         lvl_ok_ff <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------
   // Free-running divider, frozen in stop mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         psc_ff <= PSC_RST;
      end else if (!stop_mode_i) begin
         psc_ff <= psc_ff + 11'h001;
      end
   end

   // ------------------------------------------------------------
   // Mode registers
   // ------------------------------------------------------------
   // Free timer mode and pin function
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tma_ff <= NIB_RST;
         event_pin_function_select_ff <= NIB_RST;
         timer_b_mode_two_ff <= MODE2_RST;
      end else if (wr) begin
         if (idx == IDX_TA_MODE) begin
            tma_ff <= wd;
         end
         if (idx == IDX_PIN_SEL) begin
            event_pin_function_select_ff <= wd;
         end
         if (idx == IDX_TB_MODE2) begin
            timer_b_mode_two_ff <= wd[2:0];
         end
      end
   end

   // Mode one: write held pending, applied two cycles later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_b_mode_one_pend_ff <= NIB_RST;
         lag_ff <= 2'h0;
      end else if (wr && idx == IDX_TB_MODE1) begin
         timer_b_mode_one_pend_ff <= wd;
         lag_ff <= MODE_LAT_CYC;
      end else if (lag_ff != 2'h0) begin
         lag_ff <= lag_ff - 2'h1;
      end
   end

   // Active mode one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_b_mode_one_ff <= NIB_RST;
      end else if (lag_ff == 2'h1) begin
         timer_b_mode_one_ff <= timer_b_mode_one_pend_ff;
      end
   end

   // ------------------------------------------------------------
   // Load register
   // ------------------------------------------------------------
   // High digit has no documented reset; cleared to keep it defined
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_b_load_low_ff <= NIB_RST;
         timer_b_load_high_ff <= NIB_RST;
      end else begin
         if (wr_tb_low) begin
            timer_b_load_low_ff <= wd;
         end
         if (wr_tb_high) begin
            timer_b_load_high_ff <= wd;
         end
      end
   end

   // ------------------------------------------------------------
   // Free-running timer
   // ------------------------------------------------------------
   logic ta_tick, ta_ovf;
   assign ta_tick = ~stop_mode_i & tap_tick(psc_ff, tma_ff[2:0]);
   assign ta_ovf = ta_tick & (ta_ff == CNT_MAX);

   // Count and wrap
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ta_ff <= CNT_ZERO;
      end else if (ta_tick) begin
         ta_ff <= ta_ff + 8'h01;
      end
   end

   // Overflow flag: set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         free_timer_overflow_flag_ff <= 1'b0;
      end else if (ta_ovf) begin
         free_timer_overflow_flag_ff <= 1'b1;
      end else if (wr_ifa && !wd[FREE_FLAG_BIT]) begin
         free_timer_overflow_flag_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Multifunction timer
   // ------------------------------------------------------------
   logic cap_en, ext_src, tb_tick, tb_ovf, cap_evt;
   assign cap_en = timer_b_mode_two_ff[CAP_EN_BIT];
   assign ext_src = (timer_b_mode_one_ff[2:0] == SRC_EXT);
   // Capture mode counts internal taps only
   assign tb_tick = ext_src ? (evt_edge & ~cap_en)
                            : (~stop_mode_i & tap_tick(psc_ff, timer_b_mode_one_ff[2:0]));
   assign cap_evt = cap_en & evt_edge;
   assign tb_ovf = tb_tick & (tb_ff == CNT_MAX);

   // Load has priority, then capture, then counting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tb_ff <= CNT_ZERO;
      end else if (wr_tb_high) begin
         tb_ff <= {wd, timer_b_load_low_ff};
      end else if (cap_evt) begin
         tb_ff <= CNT_ZERO;
      end else if (tb_ovf) begin
         // Reload or restart
         tb_ff <= timer_b_mode_one_ff[RELOAD_BIT] ? {timer_b_load_high_ff, timer_b_load_low_ff} : CNT_ZERO;
      end else if (tb_tick) begin
         tb_ff <= tb_ff + 8'h01;
      end
   end

   // Capture copy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_ff <= CNT_ZERO;
      end else if (cap_evt) begin
         cap_ff <= tb_ff;
      end
   end

   // Request flag: set wins over clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         multi_timer_request_flag_ff <= 1'b0;
      end else if (tb_ovf || cap_evt) begin
         multi_timer_request_flag_ff <= 1'b1;
      end else if (wr_ifb && !wd[MULTI_FLAG_BIT]) begin
         multi_timer_request_flag_ff <= 1'b0;
      end
   end

   // Capture status and error flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         capture_status_flag_ff <= 1'b0;
         capture_error_flag_ff <= 1'b0;
      end else begin
         if (cap_evt) begin
            capture_status_flag_ff <= 1'b1;
         end else if (wr_cap && !wd[CSF_BIT]) begin
            capture_status_flag_ff <= 1'b0;
         end
         if (capture_status_flag_ff && (cap_evt || tb_ovf)) begin
            capture_error_flag_ff <= 1'b1;
         end else if (wr_cap && !wd[CEF_BIT]) begin
            capture_error_flag_ff <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // High read latches low digit outside capture mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lat_ff <= NIB_RST;
      end else if (rd && idx == IDX_TB_HIGH && !cap_en) begin
         lat_ff <= tb_ff[3:0];
      end
   end

   // Read data mux; write-only and unmapped read zero
   logic [3:0] rnib;
   always_comb begin
      rnib = 4'h0;
      case (idx)
         IDX_FREE_FLAG: rnib[FREE_FLAG_BIT] = free_timer_overflow_flag_ff;
         IDX_MULTI_FLAG: rnib[MULTI_FLAG_BIT] = multi_timer_request_flag_ff;
         IDX_CAP_FLAGS: rnib = {2'b00, capture_error_flag_ff, capture_status_flag_ff};
         IDX_TB_LOW: rnib = cap_en ? cap_ff[3:0] : lat_ff;
         IDX_TB_HIGH: rnib = cap_en ? cap_ff[7:4] : tb_ff[7:4];
         default: rnib = 4'h0;
      endcase
   end

   // One-wait-state Wishbone answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         rd_ff <= 32'h00000000;
      end else begin
         ack_ff <= take;
         if (rd) begin
            rd_ff <= {28'h0000000, rnib};
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rd_ff;
   assign free_timer_overflow_flag_o = free_timer_overflow_flag_ff;
   assign multi_timer_request_flag_o = multi_timer_request_flag_ff;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   psc_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> psc_ff == PSC_RST)
      else $error("prescaler not zero after reset");
   psc_halt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      stop_mode_i |=> psc_ff == $past(psc_ff))
      else $error("prescaler moved in stop mode");
   ta_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ta_tick && ta_ff != CNT_MAX |=> ta_ff == $past(ta_ff) + 8'h01)
      else $error("free timer step wrong");
   ta_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ta_ovf |=> ta_ff == CNT_ZERO && free_timer_overflow_flag_ff)
      else $error("free timer wrap wrong");
   tb_reload_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tb_ovf && !wr_tb_high && !cap_evt && timer_b_mode_one_ff[RELOAD_BIT]
      |=> tb_ff == {$past(timer_b_load_high_ff), $past(timer_b_load_low_ff)})
      else $error("reload value wrong");
   req_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      tb_ovf |=> multi_timer_request_flag_ff [*1] ##0 multi_timer_request_flag_o)
      else $error("request flag not set");
   cap_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
      cap_evt && !wr_tb_high |=> cap_ff == $past(tb_ff) && tb_ff == CNT_ZERO && capture_status_flag_ff)
      else $error("capture wrong");

   cap_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
      capture_status_flag_ff && (cap_evt || tb_ovf) |=> capture_error_flag_ff)
      else $error("capture error not set");

   mode_lag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == IDX_TB_MODE1 |-> ##3 timer_b_mode_one_ff == $past(wd, 3))
      else $error("mode one lag wrong");

   load_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_tb_high |=> tb_ff == {$past(wd), $past(timer_b_load_low_ff)})
      else $error("load from digits wrong");

endmodule
